// ---- design/ftid_defs.vh ----
/*
  Constants for the fourteen-bit instruction decoder: opcode fields,
  encodings, file addresses and status bit positions.
  Assumes it is included by its bare name from design files.
*/
`ifndef FTID_DEFS_VH
`define FTID_DEFS_VH
// How it works
// RULE1 - Destination bit picks work or file.
// RULE2 - Decode add and subtract; update carry flags.
// RULE3 - Subtract carry is inverted borrow.
// RULE4 - Decode and, or, xor, complement; zero only.
// RULE5 - Increment, decrement, move: one cycle, zero.
// RULE6 - Rotates touch carry; nibble exchange no flags.
// RULE7 - Decrement/increment skip next when zero.
// RULE8 - Store work to file; no operation.
// RULE9 - Clear file or work sets zero.
// RULE10 - Bit clear, set, test skip clear/set.
// RULE11 - True skip discards fetched word, runs no-op.
// RULE12 - Counter change or true test: two cycles.
// RULE13 - Call pushes return, loads counter with latch.
// RULE14 - Jump loads literal address, two cycles.
// RULE15 - Decode literal load, return, logic, arithmetic.
// RULE16 - Return and interrupt return take two cycles.
// RULE17 - Watchdog clear and standby update status bits.
// RULE18 - Watchdog clear also clears assigned prescaler.
// RULE19 - Timer write clears prescaler when assigned.
// RULE20 - Port read-modify-write uses pin values.
// RULE21 - Unknown words execute as one-cycle no-op.
`define FTID_PRE_FILE    2'h0
`define FTID_PRE_BIT     2'h1
`define FTID_PRE_CTRL    2'h2
`define FTID_PRE_LIT     2'h3
`define FTID_OP_MISC     4'h0
`define FTID_OP_CLR      4'h1
`define FTID_OP_SUB      4'h2
`define FTID_OP_DEC      4'h3
`define FTID_OP_IOR      4'h4
`define FTID_OP_AND      4'h5
`define FTID_OP_XOR      4'h6
`define FTID_OP_ADD      4'h7
`define FTID_OP_MOV      4'h8
`define FTID_OP_COM      4'h9
`define FTID_OP_INC      4'hA
`define FTID_OP_DECSZ    4'hB
`define FTID_OP_RRC      4'hC
`define FTID_OP_RLC      4'hD
`define FTID_OP_SWAP     4'hE
`define FTID_OP_INCSZ    4'hF
`define FTID_W_RETURN    14'h0008
`define FTID_W_RETINT    14'h0009
`define FTID_W_WDTCLR    14'h0064
`define FTID_W_SLEEP     14'h0063
`define FTID_W_CLRWORK   14'h0103
`define FTID_ADDR_TIMER_ZERO_COUNT   7'h01
`define FTID_ST_C        0
`define FTID_ST_DC       1
`define FTID_ST_Z        2
`define FTID_ST_PD       3
`define FTID_ST_TO       4
`define FTID_ST_RESET    5'h18
`endif

// ---- design/ftid_core.v ----
/*
  Execute stage of a core with a 14-bit instruction word. It takes one
  fetched word per instruction cycle, reads its file operand from the
  data space, and returns the file write, the working register, status
  flags, program counter and stack actions.
  Assumes the data space answers reads in the same cycle and that an
  instruction cycle is one enable pulse of sys_clk_i.
*/
`timescale 1ns/10ps
`include "ftid_defs.vh"
module ftid_core #(
  parameter PC_W = 13
) (
  input  wire            sys_clk_i,
  input  wire            rst_n_i,
  input  wire            cyc_en_i,
  input  wire [13:0]     instr_i,
  input  wire [PC_W-1:0] pc_i,
  input  wire [7:0]      file_rd_i,
  input  wire [7:0]      pin_rd_i,
  input  wire            file_is_port_i,
  input  wire [4:0]      pc_high_latch_i,
  input  wire            prescaler_assignment_i,
  output reg  [6:0]      file_addr_o,
  output reg  [7:0]      file_wr_data_o,
  output reg             file_wr_o,
  output reg  [7:0]      work_o,
  output reg  [4:0]      status_o,
  output reg             jump_o,
  output reg  [PC_W-1:0] jump_addr_o,
  output reg             push_o,
  output reg  [PC_W-1:0] push_addr_o,
  output reg             pop_o,
  output reg             retint_o,
  output reg             flush_o,
  output reg             wdt_clear_o,
  output reg             sleep_o,
  output reg             prescale_clear_o
);
  localparam ST_RUN   = 2'b01;
  localparam ST_FLUSH = 2'b10;

  reg  [1:0]      state_q;
  reg  [1:0]      state_d;
  reg  [7:0]      work_d;
  reg  [4:0]      status_d;
  reg  [7:0]      res;
  reg             wr_file;
  reg             wr_work;
  reg             skip;
  reg             chg_pc;
  reg  [PC_W-1:0] tgt;
  reg             do_push;
  reg             do_pop;
  reg             do_ri;
  reg             do_wdt;
  reg             do_slp;
  reg  [8:0]      sum;
  reg  [4:0]      nib;
  reg  [7:0]      bmask;

  wire [1:0] pre  = instr_i[13:12];
  wire [3:0] op   = instr_i[11:8];
  wire       dst  = instr_i[7];
  wire [6:0] fadr = instr_i[6:0];
  wire [2:0] bsel = instr_i[9:7];
  wire [7:0] lit  = instr_i[7:0];
  wire [7:0] pin_sync;

  // Pins move with no regard to sys_clk_i. Each bit passes three stages
  // and a change is taken once the second and third agree, so a glitch
  // or a metastable first stage never reaches an operand; the price is
  // that a port operand lags its pins by four clock cycles.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin_sync
      reg pin_s1_q;
      reg pin_s2_q;
      reg pin_s3_q;
      reg pin_ok_q;
      always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_s1_q <= 1'b0;
          pin_s2_q <= 1'b0;
          pin_s3_q <= 1'b0;
          pin_ok_q <= 1'b0;
        end else begin
          pin_s1_q <= pin_rd_i[gi];
          pin_s2_q <= pin_s1_q;
          pin_s3_q <= pin_s2_q;
          if (pin_s2_q == pin_s3_q)
            pin_ok_q <= pin_s3_q;
        end
      end
      assign pin_sync[gi] = pin_ok_q;
    end
  endgenerate

  // Port operands come from the pins, not the latch. [RULE20]
  wire [7:0] src  = file_is_port_i ? pin_sync : file_rd_i;
  wire       flushing = (state_q == ST_FLUSH);

  always @* begin
    // Unregistered on purpose: the data space answers in the same cycle,
    // and a register here would cost a whole instruction cycle.
    file_addr_o = fadr;
    res     = 8'h00;
    wr_file = 1'b0;
    wr_work = 1'b0;
    skip    = 1'b0;
    chg_pc  = 1'b0;
    tgt     = pc_i;
    do_push = 1'b0;
    do_pop  = 1'b0;
    do_ri   = 1'b0;
    do_wdt  = 1'b0;
    do_slp  = 1'b0;
    sum     = 9'h000;
    nib     = 5'h00;
    bmask   = 8'h01 << bsel;
    work_d  = work_o;
    status_d = status_o;
    // A flushed slot runs as a no-op so no state changes. [RULE11]
    if (!flushing) begin
      case (pre)
        `FTID_PRE_FILE: begin
          case (op)
            `FTID_OP_MISC: begin
              if (dst) begin
                res = work_o; // [RULE8]
                wr_file = 1'b1;
              end else if (instr_i == `FTID_W_RETURN) begin
                do_pop = 1'b1; // [RULE16]
                chg_pc = 1'b1;
              end else if (instr_i == `FTID_W_RETINT) begin
                do_pop = 1'b1; // [RULE16]
                do_ri  = 1'b1;
                chg_pc = 1'b1;
              end else if (instr_i == `FTID_W_WDTCLR) begin
                do_wdt = 1'b1; // [RULE17]
                status_d[`FTID_ST_TO] = 1'b1;
                status_d[`FTID_ST_PD] = 1'b1;
              end else if (instr_i == `FTID_W_SLEEP) begin
                do_slp = 1'b1; // [RULE17]
                status_d[`FTID_ST_TO] = 1'b1;
                status_d[`FTID_ST_PD] = 1'b0;
              end
              // Other words, the no-op among them, do nothing. [RULE8]
              // [RULE21]
            end
            `FTID_OP_CLR: begin
              if (dst) begin
                res = 8'h00; // [RULE9]
                wr_file = 1'b1;
                status_d[`FTID_ST_Z] = 1'b1;
              end else if (instr_i == `FTID_W_CLRWORK) begin
                work_d = 8'h00; // [RULE9]
                status_d[`FTID_ST_Z] = 1'b1;
              end
            end
            default: begin
              case (op)
                `FTID_OP_ADD: begin
                  sum = {1'b0, src} + {1'b0, work_o}; // [RULE2]
                  nib = {1'b0, src[3:0]} + {1'b0, work_o[3:0]};
                end
                `FTID_OP_SUB: begin
                  // Two's complement: carry out is the inverse borrow.
                  sum = {1'b0, src} + {1'b0, ~work_o} + 9'h001; // [RULE3]
                  nib = {1'b0, src[3:0]} + {1'b0, ~work_o[3:0]} + 5'h01;
                end
                default: begin
                  sum = 9'h000;
                  nib = 5'h00;
                end
              endcase
              case (op)
                `FTID_OP_ADD,
                `FTID_OP_SUB:   res = sum[7:0]; // [RULE2]
                `FTID_OP_AND:   res = src & work_o; // [RULE4]
                `FTID_OP_IOR:   res = src | work_o; // [RULE4]
                `FTID_OP_XOR:   res = src ^ work_o; // [RULE4]
                `FTID_OP_COM:   res = ~src; // [RULE4]
                `FTID_OP_INC,
                `FTID_OP_INCSZ: res = src + 8'h01; // [RULE5] [RULE7]
                `FTID_OP_DEC,
                `FTID_OP_DECSZ: res = src - 8'h01; // [RULE5] [RULE7]
                `FTID_OP_MOV:   res = src; // [RULE5]
                `FTID_OP_RLC:   res = {src[6:0], status_o[`FTID_ST_C]};
                `FTID_OP_RRC:   res = {status_o[`FTID_ST_C], src[7:1]};
                `FTID_OP_SWAP:  res = {src[3:0], src[7:4]}; // [RULE6]
                default:        res = src;
              endcase
              case (op)
                `FTID_OP_ADD, `FTID_OP_SUB: begin
                  status_d[`FTID_ST_C]  = sum[8]; // [RULE2] [RULE3]
                  status_d[`FTID_ST_DC] = nib[4];
                  status_d[`FTID_ST_Z]  = (res == 8'h00);
                end
                `FTID_OP_AND, `FTID_OP_IOR, `FTID_OP_XOR, `FTID_OP_COM,
                `FTID_OP_INC, `FTID_OP_DEC, `FTID_OP_MOV:
                  status_d[`FTID_ST_Z] = (res == 8'h00); // [RULE4] [RULE5]
                `FTID_OP_RLC: status_d[`FTID_ST_C] = src[7]; // [RULE6]
                `FTID_OP_RRC: status_d[`FTID_ST_C] = src[0]; // [RULE6]
                `FTID_OP_DECSZ,
                `FTID_OP_INCSZ: skip = (res == 8'h00); // [RULE7]
                default: status_d = status_o;
              endcase
              wr_file = dst; // [RULE1]
              wr_work = !dst; // [RULE1]
            end
          endcase
        end
        `FTID_PRE_BIT: begin
          case (op[3:2])
            2'b00: begin
              res = src & ~bmask; // [RULE10]
              wr_file = 1'b1;
            end
            2'b01: begin
              res = src | bmask; // [RULE10]
              wr_file = 1'b1;
            end
            2'b10: skip = ((src & bmask) == 8'h00); // [RULE10]
            default: skip = ((src & bmask) != 8'h00); // [RULE10]
          endcase
        end
        `FTID_PRE_CTRL: begin
          // Calls and jumps both take their high bits from the latch.
          chg_pc = 1'b1; // [RULE14]
          tgt = {pc_high_latch_i[4:3], instr_i[10:0]}; // [RULE13]
          do_push = !instr_i[11]; // [RULE13]
        end
        default: begin
          case (op[3:2])
            2'b00: work_d = lit; // [RULE15]
            2'b01: begin
              work_d = lit; // [RULE15] [RULE16]
              do_pop = 1'b1;
              chg_pc = 1'b1;
            end
            2'b10: begin
              case (op[1:0])
                2'b00: work_d = lit | work_o; // [RULE15]
                2'b01: work_d = lit & work_o;
                2'b10: work_d = lit ^ work_o;
                default: work_d = work_o; // [RULE21]
              endcase
              if (op[1:0] != 2'b11)
                status_d[`FTID_ST_Z] = (work_d == 8'h00);
            end
            default: begin
              if (op[1]) begin
                sum = {1'b0, lit} + {1'b0, work_o}; // [RULE15]
                nib = {1'b0, lit[3:0]} + {1'b0, work_o[3:0]};
              end else begin
                sum = {1'b0, lit} + {1'b0, ~work_o} + 9'h001; // [RULE3]
                nib = {1'b0, lit[3:0]} + {1'b0, ~work_o[3:0]} + 5'h01;
              end
              work_d = sum[7:0];
              status_d[`FTID_ST_C]  = sum[8];
              status_d[`FTID_ST_DC] = nib[4];
              status_d[`FTID_ST_Z]  = (sum[7:0] == 8'h00);
            end
          endcase
        end
      endcase
    end
    // A work destination takes the file result computed above.
    if (wr_work)
      work_d = res;
  end

  // A true test or a counter load burns the next slot. [RULE12]
  always @* begin
    case (state_q)
      ST_RUN: begin
        if (skip || chg_pc)
          state_d = ST_FLUSH; // [RULE11]
        else
          state_d = ST_RUN;
      end
      ST_FLUSH: state_d = ST_RUN;
      default:  state_d = ST_RUN;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q          <= ST_RUN;
      work_o           <= 8'h00;
      // Timeout and powerdown start set, as after power-up.
      status_o         <= `FTID_ST_RESET;
      file_wr_data_o   <= 8'h00;
      file_wr_o        <= 1'b0;
      jump_o           <= 1'b0;
      jump_addr_o      <= {PC_W{1'b0}};
      push_o           <= 1'b0;
      push_addr_o      <= {PC_W{1'b0}};
      pop_o            <= 1'b0;
      retint_o         <= 1'b0;
      flush_o          <= 1'b0;
      wdt_clear_o      <= 1'b0;
      sleep_o          <= 1'b0;
      prescale_clear_o <= 1'b0;
    end else begin
      file_wr_o        <= 1'b0;
      jump_o           <= 1'b0;
      push_o           <= 1'b0;
      pop_o            <= 1'b0;
      retint_o         <= 1'b0;
      flush_o          <= 1'b0;
      wdt_clear_o      <= 1'b0;
      sleep_o          <= 1'b0;
      prescale_clear_o <= 1'b0;
      // Nothing but the pulses moves between instruction cycles.
      if (cyc_en_i) begin
        state_q        <= state_d;
        work_o         <= work_d;
        status_o       <= status_d;
        file_wr_data_o <= res;
        file_wr_o      <= wr_file;
        // Returns take their address from the stack, not from here.
        jump_o         <= do_push | (chg_pc & !do_pop) ;
        jump_addr_o    <= tgt;
        push_o         <= do_push; // [RULE13]
        push_addr_o    <= pc_i + {{(PC_W-1){1'b0}}, 1'b1};
        pop_o          <= do_pop;
        retint_o       <= do_ri;
        flush_o        <= skip | chg_pc; // [RULE11]
        wdt_clear_o    <= do_wdt;
        sleep_o        <= do_slp;
        // Prescaler clear on watchdog clear or timer write. [RULE18]
        prescale_clear_o <= (do_wdt & prescaler_assignment_i) |
          (wr_file & (fadr == `FTID_ADDR_TIMER_ZERO_COUNT) &
           !prescaler_assignment_i); // [RULE19]
      end
    end
  end
endmodule // ftid_core

// ---- tb/ftid_mem_model.sv ----
/*
  Data space model: 128 bytes read in the same cycle, port at 05h.
  Assumes a write belongs to the address of the word last taken.
*/
`timescale 1ns/10ps
module ftid_mem_model (
  input  wire       sys_clk_i,
  input  wire       cyc_en_i,
  input  wire [6:0] file_addr_i,
  input  wire       file_wr_i,
  input  wire [7:0] file_wr_data_i,
  output wire [7:0] file_rd_o,
  output wire       file_is_port_o,
  output wire [7:0] pin_rd_o
);
  reg [7:0] mem [0:127];
  reg [6:0] addr_q;
  // Pins differ from the latch, so reading the latch is caught.
  assign file_is_port_o = (file_addr_i == 7'h05);
  assign pin_rd_o       = 8'h3C;
  assign file_rd_o      = mem[file_addr_i];
  always @(posedge sys_clk_i) begin
    if (cyc_en_i)
      addr_q <= file_addr_i;
    if (file_wr_i)
      mem[addr_q] <= file_wr_data_i;
  end
endmodule // ftid_mem_model

// ---- tb/ftid_core_asserts.sv ----
/*
  Checker for the execute stage, watching only its ports.
  Assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/10ps
`include "ftid_defs.vh"
module ftid_core_chk #(
  parameter PC_W = 13
) (
  input wire            sys_clk_i,
  input wire            rst_n_i,
  input wire            cyc_en_i,
  input wire [13:0]     instr_i,
  input wire [PC_W-1:0] pc_i,
  input wire [4:0]      pc_high_latch_i,
  input wire            prescaler_assignment_i,
  input wire            file_wr_o,
  input wire [7:0]      work_o,
  input wire [4:0]      status_o,
  input wire            jump_o,
  input wire [PC_W-1:0] jump_addr_o,
  input wire            push_o,
  input wire [PC_W-1:0] push_addr_o,
  input wire            pop_o,
  input wire            retint_o,
  input wire            flush_o,
  input wire            wdt_clear_o,
  input wire            sleep_o,
  input wire            prescale_clear_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_push_return: assert property (
    push_o |-> jump_o && push_addr_o == $past(pc_i) + 1'b1)
    else $error("return address wrong");
  a_jump_target: assert property (
    jump_o |-> jump_addr_o[10:0] == $past(instr_i[10:0])
    && jump_addr_o[PC_W-1:11] == $past(pc_high_latch_i[4:3]))
    else $error("jump target wrong");
  a_redirect_flush: assert property (
    jump_o || pop_o |-> flush_o) else $error("redirect without flush");
  a_retint_pop: assert property (
    retint_o |-> pop_o && $past(instr_i) == `FTID_W_RETINT)
    else $error("interrupt return wrong");
  a_dest_file: assert property (
    file_wr_o && $past(instr_i[13:12]) == 2'b00 |-> $past(instr_i[7]))
    else $error("file written with work destination");
  a_wdt_status: assert property (
    wdt_clear_o |-> status_o[4:3] == 2'b11) else $error("watchdog status");
  a_sleep_status: assert property (
    sleep_o |-> status_o[4:3] == 2'b10) else $error("standby status");
  a_wdt_presc: assert property (
    wdt_clear_o |-> prescale_clear_o == $past(prescaler_assignment_i))
    else $error("prescaler clear on watchdog clear");
  a_idle_hold: assert property (
    !$past(cyc_en_i) |-> $stable(work_o) && $stable(status_o)
    && !file_wr_o && !flush_o) else $error("state moved without enable");
endmodule // ftid_core_chk
bind ftid_core ftid_core_chk #(.PC_W(PC_W)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cyc_en_i(cyc_en_i),
  .instr_i(instr_i), .pc_i(pc_i), .pc_high_latch_i(pc_high_latch_i),
  .prescaler_assignment_i(prescaler_assignment_i), .file_wr_o(file_wr_o),
  .work_o(work_o), .status_o(status_o), .jump_o(jump_o),
  .jump_addr_o(jump_addr_o), .push_o(push_o), .push_addr_o(push_addr_o),
  .pop_o(pop_o), .retint_o(retint_o), .flush_o(flush_o),
  .wdt_clear_o(wdt_clear_o), .sleep_o(sleep_o),
  .prescale_clear_o(prescale_clear_o));

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the execute stage and a data space model.
  Assumes one word per two clocks, so every pulse is seen on its own.
*/
`timescale 1ns/10ps
`include "ftid_defs.vh"
module testbench;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         en = 1'b0;
  reg  [13:0] ins = 14'h0000;
  reg  [12:0] pc = 13'h0100;
  reg  [4:0]  lat = 5'h18;
  reg         prescaler_assignment = 1'b0;
  wire [7:0]  rd, pin, wd, work;
  wire [6:0]  fa;
  wire [4:0]  st;
  wire [12:0] ja, pa;
  wire        port, wr, jmp, psh, pop, rti, fl, wdc, slp, pcl;
  integer     error_cnt = 0;
  integer     n_tests = 0;
  integer     i;
  localparam [31:0] OPS = {`FTID_OP_AND, `FTID_OP_IOR, `FTID_OP_XOR,
    `FTID_OP_COM, `FTID_OP_INC, `FTID_OP_DEC, `FTID_OP_MOV, `FTID_OP_SWAP};
  localparam [63:0] RES = 64'hA5AF_AA5A_A6A4_A55A ^ 64'hA000_0000_0000_0000;
  always #5 clk = ~clk;
  ftid_core dut (.sys_clk_i(clk), .rst_n_i(rst_n), .cyc_en_i(en),
    .instr_i(ins), .pc_i(pc), .file_rd_i(rd), .pin_rd_i(pin),
    .file_is_port_i(port), .pc_high_latch_i(lat),
    .prescaler_assignment_i(prescaler_assignment), .file_addr_o(fa), .file_wr_data_o(wd),
    .file_wr_o(wr), .work_o(work), .status_o(st), .jump_o(jmp),
    .jump_addr_o(ja), .push_o(psh), .push_addr_o(pa), .pop_o(pop),
    .retint_o(rti), .flush_o(fl), .wdt_clear_o(wdc), .sleep_o(slp),
    .prescale_clear_o(pcl));
  ftid_mem_model mem (.sys_clk_i(clk), .cyc_en_i(en), .file_addr_i(fa),
    .file_wr_i(wr), .file_wr_data_i(wd), .file_rd_o(rd),
    .file_is_port_o(port), .pin_rd_o(pin));
  task ck(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task ex(input [13:0] w);
    begin
      @(posedge clk);
      ins <= w;
      en <= 1'b1;
      @(posedge clk);
      en <= 1'b0;
      #1;
    end
  endtask
  task ws(input [7:0] w, input [4:0] s);
    ck("work_status", {work, 3'h0, st}, {w, 3'h0, s});
  endtask
  task wrc(input [7:0] d);
    ck("file_write", {wr, wd}, {1'b1, d});
  endtask
  task end_sim;
    begin
      if (error_cnt == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
  initial begin
    mem.mem[7'h20] = 8'h03;
    mem.mem[7'h21] = 8'h01;
    mem.mem[7'h22] = 8'hA5;
    mem.mem[7'h23] = 8'h01;
    mem.mem[7'h24] = 8'hFE;
    mem.mem[7'h05] = 8'hC3;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    ex(14'h300F);
    ex(14'h3E01);
    ws(8'h10, 5'h1A);
    ex(14'h3C10);
    ws(8'h00, 5'h1F);
    ex(14'h3002);
    ex(14'h02A0);
    ck("sub", {wr, wd, 2'h0, st}, 16'h809B);
    ex(14'h02A1);
    ck("sub", {wr, wd, 2'h0, st}, 16'hFF98);
    ex(14'h0720);
    ck("add", {wr, work, 2'h0, st}, 16'h0198);
    for (i = 0; i < 8; i = i + 1) begin
      ex(14'h300F);
      ex({2'b00, OPS[31-4*i -: 4], 8'h22});
      ws(RES[63-8*i -: 8], 5'h18);
    end
    ex(14'h0D22);
    ws(8'h4A, 5'h19);
    ex(14'h0C22);
    ws(8'hD2, 5'h19);
    ex(14'h0BA3);
    ck("dec_skip", {fl, wr, wd}, 16'h0300);
    ex(14'h3055);
    ex(14'h0F21);
    ck("flush", fl, 1'b1);
    ex(14'h3055);
    ws(8'h00, 5'h19);
    ex(14'h1824);
    ck("flush", fl, 1'b1);
    ex(14'h3055);
    ex(14'h1C24);
    ck("flush", fl, 1'b0);
    ex(14'h3055);
    ws(8'h55, 5'h19);
    ex(14'h13A2);
    wrc(8'h25);
    ex(14'h14A2);
    wrc(8'h27);
    ex(14'h01A2);
    wrc(8'h00);
    ex(14'h0103);
    ws(8'h00, 5'h1D);
    ex(14'h3077);
    ex(14'h00A2);
    wrc(8'h77);
    ex(14'h0000);
    ex(14'h3B00);
    ck("no_op", {wr, work, 2'h0, st}, 16'h3B9D);
    ex(14'h0805);
    ws(8'h3C, 5'h19);
    ex(14'h0081);
    ck("pre_clear", pcl, 1'b1);
    ex(14'h0801);
    ck("pre_clear", pcl, 1'b0);
    prescaler_assignment <= 1'b1;
    ex(14'h0081);
    ck("pre_clear", pcl, 1'b0);
    ex(14'h0064);
    ck("wdt", {wdc, pcl, st[4:3]}, 4'hF);
    ex(14'h0063);
    ck("sleep", {slp, st[4:3]}, 3'h6);
    prescaler_assignment <= 1'b0;
    ex(14'h0064);
    ck("wdt", {wdc, pcl}, 2'h2);
    ex(14'h2123);
    ck("call", {jmp, psh, fl, ja}, 16'hF923);
    ck("push_addr", pa, 13'h0101);
    ex(14'h0000);
    ex(14'h2FFF);
    ck("jump", {jmp, psh, ja}, 15'h5FFF);
    ex(14'h0000);
    ex(14'h0008);
    ck("return", {pop, rti, fl}, 3'h5);
    ex(14'h0000);
    ex(14'h0009);
    ck("retint", {pop, rti}, 2'h3);
    ex(14'h0000);
    ex(14'h3499);
    ck("ret_lit", {pop, work}, 9'h199);
    ex(14'h0000);
    end_sim;
  end
endmodule // testbench
